// ===== core/iqc_clipper.v
// iq peak clipper: register file, per-segment settings and clip datapath
`default_nettype none

`include "iqc_clipper_regs.vh"

module iqc_clipper #(
    parameter W = 16,
    parameter NSEG = 4
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // register port
    input wire [3:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // samples from the waveform store
    input wire i_smp_valid,
    input wire signed [W-1:0] i_smp_i,
    input wire signed [W-1:0] i_smp_q,
    output reg o_smp_ready,
    // toward the fir shaping filter
    output reg o_fir_valid,
    output reg signed [W-1:0] o_fir_i,
    output reg signed [W-1:0] o_fir_q,
    // back from the fir shaping filter
    input wire i_firret_valid,
    input wire signed [W-1:0] i_firret_i,
    input wire signed [W-1:0] i_firret_q,
    output reg o_firret_ready,
    // toward the modulator
    output reg o_mod_valid,
    output reg signed [W-1:0] o_mod_i,
    output reg signed [W-1:0] o_mod_q
);

// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_SQRT = 4'b0010;
localparam [3:0] ST_DIV = 4'b0100;
localparam [3:0] ST_OUT = 4'b1000;

// ------------------------------------------------------------
// staged settings and control
// ------------------------------------------------------------
reg [7:0] ctrl;
reg [6:0] stg_comp;
reg [6:0] stg_inph;
reg [6:0] stg_quad;
reg [15:0] stg_pmag;
reg [15:0] stg_pi;
reg [15:0] stg_pq;
reg [NSEG-1:0] seg_volatile;
reg commit_refused;
reg last_limited;

wire rect_sel = ctrl[`IQC_CTRL_RECT];
wire dual = ctrl[`IQC_CTRL_DUAL];
wire playing = ctrl[`IQC_CTRL_PLAYING];
wire [1:0] edit_seg = ctrl[`IQC_CTRL_EDIT_LO+1:`IQC_CTRL_EDIT_LO];
wire [1:0] act_seg = ctrl[`IQC_CTRL_ACT_LO+1:`IQC_CTRL_ACT_LO];
// the dual player offers no placement choice: it always clips after the fir
wire pre_fir = ctrl[`IQC_CTRL_PRE_FIR] & ~dual;

wire commit = i_wr && (i_addr == `IQC_ADDR_COMMIT);
// commit to a segment that is not in volatile memory is refused
wire commit_ok = commit && seg_volatile[edit_seg];

// percentages above the full scale are clamped so 100 stays the ceiling
// the whole word is compared so a large value cannot wrap below the ceiling
wire [6:0] wr_pct = (i_wdata > {9'h000, `IQC_PCT_FULL}) ? `IQC_PCT_FULL : i_wdata[6:0];

// ------------------------------------------------------------
// per-segment committed settings
// ------------------------------------------------------------
reg seg_rect [0:NSEG-1];
reg [6:0] seg_comp [0:NSEG-1];
reg [6:0] seg_inph [0:NSEG-1];
reg [6:0] seg_quad [0:NSEG-1];
reg [15:0] seg_pmag [0:NSEG-1];
reg [15:0] seg_pi [0:NSEG-1];
reg [15:0] seg_pq [0:NSEG-1];

genvar g;
generate
    for (g = 0; g < NSEG; g = g + 1) begin : g_seg
        always @(posedge i_clk) begin
            if (i_reset) begin
                seg_rect[g] <= 1'b0;
                seg_comp[g] <= `IQC_PCT_FULL;
                seg_inph[g] <= `IQC_PCT_FULL;
                seg_quad[g] <= `IQC_PCT_FULL;
                seg_pmag[g] <= `IQC_PEAK_RESET;
                seg_pi[g] <= `IQC_PEAK_RESET;
                seg_pq[g] <= `IQC_PEAK_RESET;
            end else if (commit_ok && (edit_seg == g)) begin
                seg_rect[g] <= rect_sel;
                seg_comp[g] <= stg_comp;
                seg_inph[g] <= stg_inph;
                seg_quad[g] <= stg_quad;
                seg_pmag[g] <= stg_pmag;
                seg_pi[g] <= stg_pi;
                seg_pq[g] <= stg_pq;
            end
        end
    end
endgenerate

// ------------------------------------------------------------
// effective settings
// ------------------------------------------------------------
// single-format modes follow staged values while stopped; the dual player
// and a playing waveform only see what was committed
wire direct = ~dual & ~playing;
wire eff_rect = direct ? rect_sel : seg_rect[act_seg];
wire [6:0] eff_comp = direct ? stg_comp : seg_comp[act_seg];
wire [6:0] eff_inph = direct ? stg_inph : seg_inph[act_seg];
wire [6:0] eff_quad = direct ? stg_quad : seg_quad[act_seg];
wire [15:0] eff_pmag = direct ? stg_pmag : seg_pmag[act_seg];
wire [15:0] eff_pi = direct ? stg_pi : seg_pi[act_seg];
wire [15:0] eff_pq = direct ? stg_pq : seg_pq[act_seg];
// the dual player clips only while on; clipping needs a volatile segment
wire clip_en = seg_volatile[act_seg] & (~dual | playing);

// threshold = peak * pct / 100, done as a reciprocal multiply
wire [39:0] prod_c = eff_pmag * eff_comp * `IQC_PCT_RECIP;
wire [39:0] prod_i = eff_pi * eff_inph * `IQC_PCT_RECIP;
wire [39:0] prod_q = eff_pq * eff_quad * `IQC_PCT_RECIP;

reg [15:0] thr_c;
reg [15:0] thr_i;
reg [15:0] thr_q;
reg byp_c;
reg byp_i;
reg byp_q;

always @(posedge i_clk) begin
    if (i_reset) begin
        thr_c <= 16'h0000;
        thr_i <= 16'h0000;
        thr_q <= 16'h0000;
        byp_c <= 1'b1;
        byp_i <= 1'b1;
        byp_q <= 1'b1;
    end else begin
        thr_c <= prod_c[31:16];
        thr_i <= prod_i[31:16];
        thr_q <= prod_q[31:16];
        // full scale bypasses the limiter so rounding can never touch a sample
        byp_c <= ~clip_en | (eff_comp == `IQC_PCT_FULL);
        byp_i <= ~clip_en | (eff_inph == `IQC_PCT_FULL);
        byp_q <= ~clip_en | (eff_quad == `IQC_PCT_FULL);
    end
end

// ------------------------------------------------------------
// clip core input selection
// ------------------------------------------------------------
wire core_valid = pre_fir ? i_smp_valid : i_firret_valid;
wire signed [W-1:0] core_i = pre_fir ? i_smp_i : i_firret_i;
wire signed [W-1:0] core_q = pre_fir ? i_smp_q : i_firret_q;
wire pass_valid = pre_fir ? i_firret_valid : i_smp_valid;
wire signed [W-1:0] pass_i = pre_fir ? i_firret_i : i_smp_i;
wire signed [W-1:0] pass_q = pre_fir ? i_firret_q : i_smp_q;

reg [3:0] state;
wire core_ready = (state == ST_IDLE);
wire take = core_valid && core_ready;

// ------------------------------------------------------------
// rectangular limiter
// ------------------------------------------------------------
wire [W:0] abs_i = core_i[W-1] ? -{core_i[W-1], core_i} : {core_i[W-1], core_i};
wire [W:0] abs_q = core_q[W-1] ? -{core_q[W-1], core_q} : {core_q[W-1], core_q};
wire lim_i = ~byp_i && (abs_i > {1'b0, thr_i});
wire lim_q = ~byp_q && (abs_q > {1'b0, thr_q});
// sign kept, magnitude held at the threshold
wire signed [W-1:0] sat_i = core_i[W-1] ? -thr_i[W-1:0] : thr_i[W-1:0];
wire signed [W-1:0] sat_q = core_q[W-1] ? -thr_q[W-1:0] : thr_q[W-1:0];
wire signed [W-1:0] rect_i = lim_i ? sat_i : core_i;
wire signed [W-1:0] rect_q = lim_q ? sat_q : core_q;

// ------------------------------------------------------------
// circular detector: compare squares to avoid a root per sample
// ------------------------------------------------------------
wire [31:0] sq_i = abs_i[15:0] * abs_i[15:0];
wire [31:0] sq_q = abs_q[15:0] * abs_q[15:0];
wire [32:0] mag_sq = {1'b0, sq_i} + {1'b0, sq_q};
wire [31:0] thr_sq = thr_c * thr_c;
wire lim_c = ~byp_c && (mag_sq > {1'b0, thr_sq});

// ------------------------------------------------------------
// circular scaler: serial root then serial divide
// ------------------------------------------------------------
// the scaler costs about 32 cycles per limited sample; peaks are rare so
// back-pressure through the ready output is the price of a small datapath
reg [4:0] cnt;
reg [31:0] rad;
reg [17:0] rem;
reg [15:0] root;
reg [16:0] dvr;
reg [14:0] quo;
reg signed [W-1:0] hold_i;
reg signed [W-1:0] hold_q;
reg [15:0] hold_thr;

wire [17:0] sq_next = {rem[15:0], rad[31:30]};
wire [17:0] sq_trial = {root, 2'b01};
wire [17:0] sq_diff = sq_next - sq_trial;
wire [16:0] dv_next = {dvr[15:0], 1'b0};
wire [16:0] dv_diff = dv_next - {1'b0, root};
wire signed [31:0] scl_i = hold_i * $signed({1'b0, quo});
wire signed [31:0] scl_q = hold_q * $signed({1'b0, quo});

always @(posedge i_clk) begin
    if (i_reset) begin
        state <= ST_IDLE;
        cnt <= 5'h00;
        rad <= 32'h0000_0000;
        rem <= 18'h0_0000;
        root <= 16'h0000;
        dvr <= 17'h0_0000;
        quo <= 15'h0000;
        hold_i <= {W{1'b0}};
        hold_q <= {W{1'b0}};
        hold_thr <= 16'h0000;
    end else begin
        case (state)
            ST_IDLE: begin
                if (take && ~eff_rect && lim_c) begin
                    state <= ST_SQRT;
                    cnt <= 5'h00;
                    rad <= mag_sq[31:0];
                    rem <= 18'h0_0000;
                    root <= 16'h0000;
                    hold_i <= core_i;
                    hold_q <= core_q;
                    hold_thr <= thr_c;
                end
            end
            ST_SQRT: begin
                rad <= {rad[29:0], 2'b00};
                if (sq_next >= sq_trial) begin
                    rem <= sq_diff;
                    root <= {root[14:0], 1'b1};
                end else begin
                    rem <= sq_next;
                    root <= {root[14:0], 1'b0};
                end
                cnt <= cnt + 5'h01;
                if (cnt == 5'h0F) begin
                    state <= ST_DIV;
                    cnt <= 5'h00;
                    dvr <= {1'b0, hold_thr};
                    quo <= 15'h0000;
                end
            end
            ST_DIV: begin
                // ratio thr / magnitude as a fraction below one
                if (dv_next >= {1'b0, root}) begin
                    dvr <= dv_diff;
                    quo <= {quo[13:0], 1'b1};
                end else begin
                    dvr <= dv_next;
                    quo <= {quo[13:0], 1'b0};
                end
                cnt <= cnt + 5'h01;
                if (cnt == 5'h0E) begin
                    state <= ST_OUT;
                end
            end
            ST_OUT: begin
                state <= ST_IDLE;
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// ------------------------------------------------------------
// output paths
// ------------------------------------------------------------
reg next_valid;
reg signed [W-1:0] next_i;
reg signed [W-1:0] next_q;
reg next_lim;

always @* begin
    next_valid = 1'b0;
    next_i = core_i;
    next_q = core_q;
    next_lim = 1'b0;
    if (state == ST_OUT) begin
        next_valid = 1'b1;
        next_i = scl_i[W-1+`IQC_FRAC_BITS:`IQC_FRAC_BITS];
        next_q = scl_q[W-1+`IQC_FRAC_BITS:`IQC_FRAC_BITS];
        next_lim = 1'b1;
    end else if (take && eff_rect) begin
        next_valid = 1'b1;
        next_i = rect_i;
        next_q = rect_q;
        next_lim = lim_i | lim_q;
    end else if (take && ~lim_c) begin
        next_valid = 1'b1;
    end
end

always @(posedge i_clk) begin
    if (i_reset) begin
        o_fir_valid <= 1'b0;
        o_fir_i <= {W{1'b0}};
        o_fir_q <= {W{1'b0}};
        o_mod_valid <= 1'b0;
        o_mod_i <= {W{1'b0}};
        o_mod_q <= {W{1'b0}};
        o_smp_ready <= 1'b0;
        o_firret_ready <= 1'b0;
        last_limited <= 1'b0;
    end else begin
        // clipped stream goes to the fir when placed before it
        o_fir_valid <= pre_fir ? next_valid : pass_valid;
        o_fir_i <= pre_fir ? next_i : pass_i;
        o_fir_q <= pre_fir ? next_q : pass_q;
        o_mod_valid <= pre_fir ? pass_valid : next_valid;
        o_mod_i <= pre_fir ? pass_i : next_i;
        o_mod_q <= pre_fir ? pass_q : next_q;
        // ready drops the cycle after a limited circular sample is taken
        o_smp_ready <= ~pre_fir | (core_ready & ~(take & ~eff_rect & lim_c) | state[3]);
        o_firret_ready <= pre_fir | (core_ready & ~(take & ~eff_rect & lim_c) | state[3]);
        if (next_valid) begin
            last_limited <= next_lim;
        end
    end
end

// ------------------------------------------------------------
// register port
// ------------------------------------------------------------
always @(posedge i_clk) begin
    if (i_reset) begin
        ctrl <= `IQC_CTRL_RESET;
        stg_comp <= `IQC_PCT_FULL;
        stg_inph <= `IQC_PCT_FULL;
        stg_quad <= `IQC_PCT_FULL;
        stg_pmag <= `IQC_PEAK_RESET;
        stg_pi <= `IQC_PEAK_RESET;
        stg_pq <= `IQC_PEAK_RESET;
        seg_volatile <= {NSEG{1'b0}};
        commit_refused <= 1'b0;
        o_rdata <= 16'h0000;
    end else begin
        if (i_wr) begin
            case (i_addr)
                `IQC_ADDR_CTRL: ctrl <= i_wdata[7:0];
                `IQC_ADDR_COMP_THR: stg_comp <= wr_pct;
                `IQC_ADDR_INPH_THR: stg_inph <= wr_pct;
                `IQC_ADDR_QUAD_THR: stg_quad <= wr_pct;
                `IQC_ADDR_PEAK_MAG: stg_pmag <= i_wdata;
                `IQC_ADDR_PEAK_I: stg_pi <= i_wdata;
                `IQC_ADDR_PEAK_Q: stg_pq <= i_wdata;
                `IQC_ADDR_VOLATILE: seg_volatile <= i_wdata[NSEG-1:0];
                default: ;
            endcase
        end
        if (commit) begin
            commit_refused <= ~commit_ok;
        end
        o_rdata <= 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `IQC_ADDR_CTRL: o_rdata <= {8'h00, ctrl};
                `IQC_ADDR_COMP_THR: o_rdata <= {9'h000, stg_comp};
                `IQC_ADDR_INPH_THR: o_rdata <= {9'h000, stg_inph};
                `IQC_ADDR_QUAD_THR: o_rdata <= {9'h000, stg_quad};
                `IQC_ADDR_PEAK_MAG: o_rdata <= stg_pmag;
                `IQC_ADDR_PEAK_I: o_rdata <= stg_pi;
                `IQC_ADDR_PEAK_Q: o_rdata <= stg_pq;
                `IQC_ADDR_VOLATILE: o_rdata <= {{(16-NSEG){1'b0}}, seg_volatile};
                `IQC_ADDR_STATUS: o_rdata <= {12'h000, last_limited, commit_refused,
                    clip_en, ~core_ready};
                default: o_rdata <= 16'h0000;
            endcase
        end
    end
end

endmodule // iqc_clipper

`default_nettype wire

// ===== core/iqc_clipper_regs.vh
// register map, field positions and reset values of the iq peak clipper
`ifndef IQC_CLIPPER_REGS_VH
`define IQC_CLIPPER_REGS_VH

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define IQC_ADDR_CTRL 4'h0
`define IQC_ADDR_COMP_THR 4'h1
`define IQC_ADDR_INPH_THR 4'h2
`define IQC_ADDR_QUAD_THR 4'h3
`define IQC_ADDR_PEAK_MAG 4'h4
`define IQC_ADDR_PEAK_I 4'h5
`define IQC_ADDR_PEAK_Q 4'h6
`define IQC_ADDR_VOLATILE 4'h7
`define IQC_ADDR_COMMIT 4'h8
`define IQC_ADDR_STATUS 4'h9

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define IQC_CTRL_RECT 0
`define IQC_CTRL_PRE_FIR 1
`define IQC_CTRL_DUAL 2
`define IQC_CTRL_PLAYING 3
`define IQC_CTRL_EDIT_LO 4
`define IQC_CTRL_ACT_LO 6

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define IQC_STAT_BUSY 0
`define IQC_STAT_CLIP_EN 1
`define IQC_STAT_REFUSED 2
`define IQC_STAT_LIMITED 3

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define IQC_CTRL_RESET 8'h00
`define IQC_PCT_FULL 7'h64
`define IQC_PEAK_RESET 16'h7FFF
`define IQC_PCT_RECIP 10'h28F
`define IQC_FRAC_BITS 15

`endif

// ===== sim/iqc_clipper_chk.sv
// checker: register and stream relations seen at the clipper ports
`default_nettype none

module iqc_clipper_chk (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // stream handshakes
    input wire logic i_smp_valid,
    input wire logic o_smp_ready,
    input wire logic o_fir_valid,
    input wire logic o_firret_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    thr_back_a: assert property (i_wr && i_addr == 4'h1 && i_wdata <= 16'h0064 ##1
        i_rd && i_addr == 4'h1 |=> o_rdata == $past(i_wdata, 2))
        else $error("composite percentage not read back");
    thr_clamp_a: assert property (i_wr && i_addr == 4'h2 && i_wdata > 16'h0064 ##1
        i_rd && i_addr == 4'h2 |=> o_rdata == 16'h0064)
        else $error("percentage above full not clamped");
    ctrl_back_a: assert property (i_wr && i_addr == 4'h0 ##1 i_rd && i_addr == 4'h0
        |=> (o_rdata & 16'h00FF) == ($past(i_wdata, 2) & 16'h00FF))
        else $error("mode control not read back");
    unmapped_zero_a: assert property (i_rd && i_addr > 4'h9 |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    commit_refused_a: assert property (i_wr && i_addr == 4'h7 && i_wdata[3:0] == 4'h0 ##1
        i_wr && i_addr == 4'h8 ##1 i_rd && i_addr == 4'h9 |=> o_rdata[2])
        else $error("commit to stored-only segment not refused");
    commit_taken_a: assert property (i_wr && i_addr == 4'h7 && i_wdata[3:0] == 4'hF ##1
        i_wr && i_addr == 4'h8 ##1 i_rd && i_addr == 4'h9 |=> !o_rdata[2])
        else $error("commit to volatile segment refused");
    stall_bound_a: assert property ($fell(o_smp_ready) |-> ##[1:40] o_smp_ready)
        else $error("scaling stall too long");
    take_fwd_a: assert property (i_smp_valid && o_smp_ready |-> ##[1:40] o_fir_valid)
        else $error("taken sample never forwarded");
    return_stall_a: assert property ($fell(o_firret_ready) |-> ##[1:40] o_firret_ready)
        else $error("fir return stall too long");
endmodule // iqc_clipper_chk

bind iqc_clipper iqc_clipper_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .o_fir_valid(o_fir_valid),
    .o_firret_ready(o_firret_ready));

`default_nettype wire

// ===== sim/iqc_fir_model.sv
// far-side model: identity fir stage returning samples to the clipper
`default_nettype none

module iqc_fir_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // from the clipper
    input wire logic i_valid,
    input wire logic signed [15:0] i_i,
    input wire logic signed [15:0] i_q,
    // back to the clipper
    input wire logic i_ready,
    output logic o_valid,
    output logic signed [15:0] o_i,
    output logic signed [15:0] o_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // one-deep hold
    // ------------------------------------------------------------
    // holds while the clipper stalls; no queue, so a word arriving while it holds is dropped
    // idle data toggle so a stale word is never mistaken for a fresh one
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_i <= 16'h0000;
            o_q <= 16'h0000;
        end else if (!o_valid || i_ready) begin
            o_valid <= i_valid;
            o_i <= i_valid ? i_i : ~o_i;
            o_q <= i_valid ? i_q : ~o_q;
        end
    end
endmodule // iqc_fir_model

`default_nettype wire

// ===== sim/iqc_clipper_bench.sv
// self-checking bench for the iq peak clipper
`default_nettype none
`include "iqc_clipper_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0d seen %0d", n, e, g); end end

module iqc_clipper_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [15:0] ctrl, tc, ti, tq, pk;
        logic signed [15:0] ii, iq, ei, eq;
    } iqc_row_t;

    logic i_clk, i_reset, i_wr, i_rd, i_smp_valid, o_smp_ready, o_fir_valid;
    logic o_firret_ready, o_mod_valid, i_firret_valid;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, v;
    logic signed [15:0] i_smp_i, i_smp_q, o_fir_i, o_fir_q, i_firret_i, i_firret_q;
    logic signed [15:0] o_mod_i, o_mod_q, got_i, got_q, fir_i;
    int bad_count, checks;
    // circular rows other than rows 3 and 5 need scaling; last two rows clip after the fir
    iqc_row_t rows [10] = '{
        '{16'h0003, 100, 50, 100, 16'h7FFF, 20000, -30000, 16374, -30000},
        '{16'h0003, 100, 75, 40, 16'h7FFF, -30000, 10000, -24561, 10000},
        '{16'h0003, 100, 100, 40, 16'h7FFF, 32767, -20000, 32767, -13099},
        '{16'h0002, 100, 100, 100, 16'h7FFF, 20000, 20000, 20000, 20000},
        '{16'h0002, 50, 100, 100, 16'h7FFF, 20000, 20000, 11577, 11577},
        '{16'h0002, 50, 100, 100, 16'h7FFF, 10000, -5000, 10000, -5000},
        '{16'h0002, 50, 100, 100, 16'h7FFF, 20000, -20000, 11577, -11578},
        '{16'h0002, 75, 100, 100, 16'h7FFF, 20000, 20000, 17366, 17366},
        '{16'h0001, 100, 50, 100, 16'h4000, 10000, -3000, 8187, -3000},
        '{16'h0000, 50, 100, 100, 16'h7FFF, 20000, 20000, 11577, 11577}};

    iqc_clipper DUT (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid),
        .i_smp_i(i_smp_i), .i_smp_q(i_smp_q), .o_smp_ready(o_smp_ready),
        .o_fir_valid(o_fir_valid), .o_fir_i(o_fir_i), .o_fir_q(o_fir_q),
        .i_firret_valid(i_firret_valid), .i_firret_i(i_firret_i), .i_firret_q(i_firret_q),
        .o_firret_ready(o_firret_ready), .o_mod_valid(o_mod_valid), .o_mod_i(o_mod_i),
        .o_mod_q(o_mod_q));
    iqc_fir_model FIR (.i_clk(i_clk), .i_reset(i_reset), .i_valid(o_fir_valid),
        .i_i(o_fir_i), .i_q(o_fir_q), .i_ready(o_firret_ready), .o_valid(i_firret_valid),
        .o_i(i_firret_i), .o_q(i_firret_q));

    // ------------------------------------------------------------
    // clock and monitors
    // ------------------------------------------------------------
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_fir_valid === 1'b1) begin
            fir_i <= o_fir_i;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // spare cycle first: a new threshold lands one cycle after its write
    task automatic send(input logic signed [15:0] si, input logic signed [15:0] sq);
        int k;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
        i_smp_valid <= 1'b1;
        i_smp_i <= si;
        i_smp_q <= sq;
        k = 0;
        do begin @(posedge i_clk); k++; end while (o_smp_ready !== 1'b1 && k < 100);
        if (o_smp_ready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        i_smp_valid <= 1'b0;
        i_smp_i <= ~si;
        i_smp_q <= ~sq;
        do begin @(posedge i_clk); #1; k++; end while (o_mod_valid !== 1'b1 && k < 200);
        if (o_mod_valid !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        got_i = o_mod_i;
        got_q = o_mod_q;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_clk, i_wr, i_rd, i_smp_valid, i_addr, i_wdata} = '0;
        {i_smp_i, i_smp_q, bad_count, checks} = '0;
        i_reset = 1'b1;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`IQC_ADDR_CTRL, v);
        `CHK("ctrl_reset", 16'h0000, v)
        rd(`IQC_ADDR_COMP_THR, v);
        `CHK("comp_reset", 16'h0064, v)
        rd(`IQC_ADDR_PEAK_MAG, v);
        `CHK("peak_reset", `IQC_PEAK_RESET, v)
        rd(4'hA, v);
        `CHK("unmapped", 16'h0000, v)
        wr(`IQC_ADDR_COMP_THR, 16'h0032);
        rd(`IQC_ADDR_COMP_THR, v);
        `CHK("comp_back", 16'h0032, v)
        wr(`IQC_ADDR_INPH_THR, 16'h00C8);
        rd(`IQC_ADDR_INPH_THR, v);
        `CHK("inph_clamp", 16'h0064, v)
        $display("register test done");
        wr(`IQC_ADDR_VOLATILE, 16'h000F);
        for (int n = 0; n < 10; n++) begin
            wr(`IQC_ADDR_CTRL, rows[n].ctrl);
            wr(`IQC_ADDR_COMP_THR, rows[n].tc);
            wr(`IQC_ADDR_INPH_THR, rows[n].ti);
            wr(`IQC_ADDR_QUAD_THR, rows[n].tq);
            wr(`IQC_ADDR_PEAK_I, rows[n].pk);
            send(rows[n].ii, rows[n].iq);
            `CHK("mod_i", rows[n].ei, got_i)
            `CHK("mod_q", rows[n].eq, got_q)
            `CHK("fir_i", rows[n].ctrl[1] ? rows[n].ei : rows[n].ii, fir_i)
            $display("row %0d done", n);
        end
        wr(`IQC_ADDR_PEAK_I, 16'h7FFF);
        wr(`IQC_ADDR_INPH_THR, 16'h0064);
        wr(`IQC_ADDR_CTRL, 16'h005D);
        rd(`IQC_ADDR_CTRL, v);
        `CHK("ctrl_back", 16'h005D, v & 16'h00FF)
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        send(20000, 5000);
        `CHK("dual_full", 20000, got_i)
        wr(`IQC_ADDR_INPH_THR, 16'h0032);
        send(20000, 5000);
        `CHK("dual_staged", 20000, got_i)
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        send(20000, 5000);
        `CHK("dual_commit", 16374, got_i)
        wr(`IQC_ADDR_VOLATILE, 16'h000D);
        send(20000, 5000);
        `CHK("dual_stored", 20000, got_i)
        wr(`IQC_ADDR_VOLATILE, 16'h0000);
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        rd(`IQC_ADDR_STATUS, v);
        `CHK("refused", 1'b1, v[2])
        wr(`IQC_ADDR_VOLATILE, 16'h000F);
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        rd(`IQC_ADDR_STATUS, v);
        `CHK("accepted", 1'b0, v[2])
        wr(`IQC_ADDR_INPH_THR, 16'h0064);
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        wr(`IQC_ADDR_INPH_THR, 16'h0032);
        wr(`IQC_ADDR_CTRL, 16'h006D);
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        send(20000, 5000);
        `CHK("inactive_commit", 20000, got_i)
        wr(`IQC_ADDR_CTRL, 16'h00AD);
        send(20000, 5000);
        `CHK("inactive_selected", 16374, got_i)
        wr(`IQC_ADDR_CTRL, 16'h00A5);
        send(20000, 5000);
        `CHK("player_off", 20000, got_i)
        wr(`IQC_ADDR_CTRL, 16'h0009);
        send(20000, 5000);
        `CHK("single_playing", 20000, got_i)
        wr(`IQC_ADDR_COMMIT, 16'h0000);
        send(20000, 5000);
        `CHK("single_commit", 16374, got_i)
        $display("dual player test done");
        report_and_stop();
    end
endmodule // iqc_clipper_bench

`default_nettype wire
